// ===== hw/pis_pkg.sv
// types shared by the interrupt source block
package pis_pkg;
  typedef struct packed {
    logic [7:0] adr;
    logic we;
    logic [7:0] dat;
    logic rd;
    logic wr;
  } pis_acc_t;
  typedef struct packed {
    logic cap_en;
    logic cmp_en;
    logic ovf_en;
    logic edge_sel;
    logic cap_ev;
    logic cmp_ev;
    logic ovf_ev;
    logic tick;
  } pis_tmr_io_t;
  typedef struct packed {
    logic cap_flag;
    logic cmp_flag;
    logic ovf_flag;
    logic cap_armed;
    logic cmp_armed;
    logic ovf_armed;
    logic [7:0] ctrl;
  } pis_tmr_state_t;
endpackage : pis_pkg

// ===== hw/pis_regs.svh
// register offsets, field positions and reset values for the interrupt source block
`ifndef PIS_REGS_SVH
`define PIS_REGS_SVH
// offsets are register indices; byte address is four times the index
`define PIS_IDX_SER_CTRL 8'h0a
`define PIS_IDX_SER_STAT 8'h0b
`define PIS_IDX_SER_BUF 8'h0c
`define PIS_IDX_CNT_HI 8'h10
`define PIS_IDX_CNT_LO 8'h11
`define PIS_IDX_TMR_CTRL 8'h12
`define PIS_IDX_TMR_STAT 8'h13
`define PIS_IDX_CAP_HI 8'h14
`define PIS_IDX_CAP_LO 8'h15
`define PIS_IDX_CMP_HI 8'h16
`define PIS_IDX_CMP_LO 8'h17
`define PIS_IDX_ANA_CTRL 8'h1d
`define PIS_IDX_ANA_STAT 8'h1e
`define PIS_IDX_CPU_CTRL 8'h1f
// timer_ctrl fields
`define PIS_TC_CAP_IE 7
`define PIS_TC_CMP_IE 6
`define PIS_TC_OVF_IE 5
`define PIS_TC_EDGE 1
// timer_stat fields
`define PIS_TS_CAP 7
`define PIS_TS_CMP 6
`define PIS_TS_OVF 5
// serial_ctrl fields
`define PIS_SC_IE 7
`define PIS_SC_CLR 6
// serial_stat fields
`define PIS_SS_DONE 7
// analog_ctrl fields
`define PIS_AC_CAP_EN 7
`define PIS_AC_IE 6
// analog_stat fields
`define PIS_AS_F1 7
`define PIS_AS_F2 6
`define PIS_AS_CLR1 5
`define PIS_AS_CLR2 4
// cpu_ctrl fields
`define PIS_CC_MASK 0
// reset values
`define PIS_CNT_RESET 16'hfffc
`endif

// ===== hw/pis_timer_flags.sv
// timer capture, compare and overflow flags with their clearing sequences
`include "pis_regs.svh"
module pis_timer_flags (
  input wire logic clk_i, // system clock
  input wire logic rst_i, // synchronous reset, high
  input wire pis_pkg::pis_acc_t acc_i, // decoded bus access, one-cycle strobes
  input wire pis_pkg::pis_tmr_io_t ev_i, // timer events, one-cycle pulses
  output logic [7:0] ctrl_o, // timer_ctrl contents
  output logic [7:0] stat_o, // timer_stat contents
  output logic irq_o // gated timer request, before global mask
);
  pis_pkg::pis_tmr_state_t st_reg, st_next;

  function automatic logic hit(input pis_pkg::pis_acc_t a, input logic [7:0] idx);
    hit = (a.rd | a.wr) && (a.adr == idx);
  endfunction : hit

  always_comb begin
    st_next = st_reg;
    if (acc_i.wr && acc_i.adr == `PIS_IDX_TMR_CTRL) begin
      st_next.ctrl = acc_i.dat;
    end
    // status read arms clearing of flags set at that read
    if (acc_i.rd && acc_i.adr == `PIS_IDX_TMR_STAT) begin
      st_next.cap_armed = st_reg.cap_flag;
      st_next.cmp_armed = st_reg.cmp_flag;
      st_next.ovf_armed = st_reg.ovf_flag;
    end
    if (st_reg.cap_armed && acc_i.rd && acc_i.adr == `PIS_IDX_CAP_LO) begin
      st_next.cap_flag = 1'b0;
      st_next.cap_armed = 1'b0;
    end
    if (st_reg.cmp_armed && hit(acc_i, `PIS_IDX_CMP_LO)) begin
      st_next.cmp_flag = 1'b0;
      st_next.cmp_armed = 1'b0;
    end
    if (st_reg.ovf_armed && hit(acc_i, `PIS_IDX_CNT_LO)) begin
      st_next.ovf_flag = 1'b0;
      st_next.ovf_armed = 1'b0;
    end
    // a new event wins over a same-cycle clear
    if (ev_i.cap_ev) begin
      st_next.cap_flag = 1'b1;
    end
    if (ev_i.cmp_ev) begin
      st_next.cmp_flag = 1'b1;
    end
    if (ev_i.ovf_ev) begin
      st_next.ovf_flag = 1'b1;
    end
    if (rst_i) begin
      st_next.cap_flag = 1'b0;
      st_next.cmp_flag = 1'b0;
      st_next.ovf_flag = 1'b0;
      st_next.cap_armed = 1'b0;
      st_next.cmp_armed = 1'b0;
      st_next.ovf_armed = 1'b0;
      st_next.ctrl = st_reg.ctrl;
    end
  end

  always_ff @(posedge clk_i) begin
    st_reg <= st_next;
  end

  assign ctrl_o = st_reg.ctrl;
  assign stat_o = {st_reg.cap_flag, st_reg.cmp_flag, st_reg.ovf_flag, 5'h00};
  assign irq_o = (st_reg.cap_flag & st_reg.ctrl[`PIS_TC_CAP_IE])
    | (st_reg.cmp_flag & st_reg.ctrl[`PIS_TC_CMP_IE])
    | (st_reg.ovf_flag & st_reg.ctrl[`PIS_TC_OVF_IE]);
endmodule : pis_timer_flags

// ===== hw/pis_top.sv
// interrupt sources for timer, serial and analog peripherals with wishbone slave
`include "pis_regs.svh"
module pis_top (
  input wire logic clk_i, // system clock, 20 MHz
  input wire logic rst_i, // synchronous reset, high
  input wire logic cyc_i, // wishbone cycle
  input wire logic stb_i, // wishbone strobe
  input wire logic we_i, // wishbone write enable
  input wire logic [9:0] adr_i, // wishbone byte address
  input wire logic [3:0] sel_i, // wishbone byte selects
  input wire logic [31:0] dat_i, // wishbone write data
  output logic [31:0] dat_o, // wishbone read data
  output logic ack_o, // wishbone acknowledge
  output logic err_o, // wishbone error, unmapped address
  input wire logic ext_capture_i, // external capture pin
  input wire logic cmp_match_i, // timer compare event, same clock
  input wire logic cnt_wrap_i, // timer overflow event, same clock
  input wire logic serial_done_i, // serial transfer complete, same clock
  input wire logic cmp1_out_i, // comparator 1 digital output, async
  input wire logic cmp2_out_i, // comparator 2 digital output, async
  output logic capture_o, // pulse: timer capture taken
  output logic irq_o // request to processor
);
  typedef struct packed {
    logic ack;
    logic err;
    logic [31:0] rdat;
    logic [7:0] ser_ctrl;
    logic ser_flag;
    logic ser_armed;
    logic [7:0] ser_buf;
    logic [7:0] ana_ctrl;
    logic f1;
    logic f2;
    logic cpu_mask;
    logic [15:0] cap_val;
    logic [15:0] cmp_val;
    logic [15:0] cnt_val;
    logic [1:0] sync1;
    logic [1:0] sync2;
    logic [1:0] c_prev;
    logic [1:0] pin_sync;
    logic pin_prev;
    logic cap_pulse;
    logic irq;
  } pis_top_state_t;

  pis_top_state_t st_reg, st_next;
  pis_pkg::pis_acc_t acc;
  pis_pkg::pis_tmr_io_t tio;
  logic [7:0] tctrl;
  logic [7:0] tstat;
  logic tirq;
  logic req;
  logic [7:0] idx;
  logic mapped;
  logic pin_edge;
  logic c2_rise;

  function automatic logic is_idx(input logic [7:0] i, input logic [7:0] want);
    is_idx = (i == want);
  endfunction : is_idx

  assign idx = adr_i[9:2];
  assign req = cyc_i & stb_i & ~st_reg.ack & ~st_reg.err;
  assign mapped = is_idx(idx, `PIS_IDX_SER_CTRL) | is_idx(idx, `PIS_IDX_SER_STAT)
    | is_idx(idx, `PIS_IDX_SER_BUF) | is_idx(idx, `PIS_IDX_CNT_HI)
    | is_idx(idx, `PIS_IDX_CNT_LO) | is_idx(idx, `PIS_IDX_TMR_CTRL)
    | is_idx(idx, `PIS_IDX_TMR_STAT) | is_idx(idx, `PIS_IDX_CAP_HI)
    | is_idx(idx, `PIS_IDX_CAP_LO) | is_idx(idx, `PIS_IDX_CMP_HI)
    | is_idx(idx, `PIS_IDX_CMP_LO) | is_idx(idx, `PIS_IDX_ANA_CTRL)
    | is_idx(idx, `PIS_IDX_ANA_STAT) | is_idx(idx, `PIS_IDX_CPU_CTRL);

  // accesses take effect once, in the request's first cycle; byte lane 0 carries data
  always_comb begin
    acc.adr = idx;
    acc.we = we_i;
    acc.dat = dat_i[7:0];
    acc.rd = req & mapped & ~we_i;
    acc.wr = req & mapped & we_i & sel_i[0];
  end

  // edge select picks which pin edge captures
  assign pin_edge = tctrl[`PIS_TC_EDGE] ? (st_reg.pin_sync[1] & ~st_reg.pin_prev)
                                         : (~st_reg.pin_sync[1] & st_reg.pin_prev);
  // comparator output reports positive above negative
  assign c2_rise = st_reg.sync2[1] & ~st_reg.c_prev[1];

  always_comb begin
    tio.cap_en = tctrl[`PIS_TC_CAP_IE];
    tio.cmp_en = tctrl[`PIS_TC_CMP_IE];
    tio.ovf_en = tctrl[`PIS_TC_OVF_IE];
    tio.edge_sel = tctrl[`PIS_TC_EDGE];
    tio.cap_ev = pin_edge | (c2_rise & st_reg.ana_ctrl[`PIS_AC_CAP_EN]);
    tio.cmp_ev = cmp_match_i;
    tio.ovf_ev = cnt_wrap_i;
    tio.tick = 1'b0;
  end

  pis_timer_flags u_tmr (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .acc_i(acc),
    .ev_i(tio),
    .ctrl_o(tctrl),
    .stat_o(tstat),
    .irq_o(tirq)
  );

  always_comb begin
    st_next = st_reg;
    st_next.ack = req & mapped;
    st_next.err = req & ~mapped;
    st_next.cap_pulse = tio.cap_ev;
    st_next.rdat = 32'h0000_0000;
    // comparator and pin inputs pass two flops before use
    st_next.sync1 = {st_reg.sync1[0], cmp1_out_i};
    st_next.sync2 = {st_reg.sync2[0], cmp2_out_i};
    st_next.c_prev = {st_reg.sync2[1], st_reg.sync1[1]};
    st_next.pin_sync = {st_reg.pin_sync[0], ext_capture_i};
    st_next.pin_prev = st_reg.pin_sync[1];
    if (tio.cap_ev) begin
      st_next.cap_val = st_reg.cnt_val;
    end
    // simple free-running counter, wraps drive nothing here
    st_next.cnt_val = st_reg.cnt_val + 16'h0001;
    if (acc.rd) begin
      case (idx)
        `PIS_IDX_SER_CTRL: st_next.rdat = {24'h000000, st_reg.ser_ctrl};
        `PIS_IDX_SER_STAT: st_next.rdat = {24'h000000, st_reg.ser_flag, 7'h00};
        `PIS_IDX_SER_BUF: st_next.rdat = {24'h000000, st_reg.ser_buf};
        `PIS_IDX_CNT_HI: st_next.rdat = {24'h000000, st_reg.cnt_val[15:8]};
        `PIS_IDX_CNT_LO: st_next.rdat = {24'h000000, st_reg.cnt_val[7:0]};
        `PIS_IDX_TMR_CTRL: st_next.rdat = {24'h000000, tctrl};
        `PIS_IDX_TMR_STAT: st_next.rdat = {24'h000000, tstat};
        `PIS_IDX_CAP_HI: st_next.rdat = {24'h000000, st_reg.cap_val[15:8]};
        `PIS_IDX_CAP_LO: st_next.rdat = {24'h000000, st_reg.cap_val[7:0]};
        `PIS_IDX_CMP_HI: st_next.rdat = {24'h000000, st_reg.cmp_val[15:8]};
        `PIS_IDX_CMP_LO: st_next.rdat = {24'h000000, st_reg.cmp_val[7:0]};
        `PIS_IDX_ANA_CTRL: st_next.rdat = {24'h000000, st_reg.ana_ctrl};
        `PIS_IDX_ANA_STAT: st_next.rdat = {24'h000000, st_reg.f1, st_reg.f2, 6'h00};
        `PIS_IDX_CPU_CTRL: st_next.rdat = {31'h00000000, st_reg.cpu_mask};
        default: st_next.rdat = 32'h0000_0000;
      endcase
    end
    // serial status read arms the clear
    if (acc.rd && idx == `PIS_IDX_SER_STAT) begin
      st_next.ser_armed = st_reg.ser_flag;
    end
    // data read or write completes clear
    if (st_reg.ser_armed && (acc.rd || acc.wr) && idx == `PIS_IDX_SER_BUF) begin
      st_next.ser_flag = 1'b0;
      st_next.ser_armed = 1'b0;
    end
    if (acc.wr) begin
      case (idx)
        `PIS_IDX_SER_CTRL: begin
          // clear bit is write-only, reads zero
          st_next.ser_ctrl = {acc.dat[7], 1'b0, acc.dat[5:0]};
          if (acc.dat[`PIS_SC_CLR]) begin
            st_next.ser_flag = 1'b0;
            st_next.ser_armed = 1'b0;
          end
        end
        `PIS_IDX_SER_BUF: st_next.ser_buf = acc.dat;
        `PIS_IDX_CNT_LO: st_next.cnt_val = `PIS_CNT_RESET;
        `PIS_IDX_CMP_HI: st_next.cmp_val[15:8] = acc.dat;
        `PIS_IDX_CMP_LO: st_next.cmp_val[7:0] = acc.dat;
        `PIS_IDX_ANA_CTRL: st_next.ana_ctrl = acc.dat;
        `PIS_IDX_ANA_STAT: begin
          if (acc.dat[`PIS_AS_CLR1]) begin
            st_next.f1 = 1'b0;
          end
          if (acc.dat[`PIS_AS_CLR2]) begin
            st_next.f2 = 1'b0;
          end
        end
        `PIS_IDX_CPU_CTRL: st_next.cpu_mask = acc.dat[`PIS_CC_MASK];
        default: st_next.ser_buf = st_reg.ser_buf;
      endcase
    end
    // flags set on comparator output, set wins over clear
    if (st_reg.sync1[1]) begin
      st_next.f1 = 1'b1;
    end
    if (st_reg.sync2[1]) begin
      st_next.f2 = 1'b1;
    end
    // serial done sets flag, wins over clear
    if (serial_done_i) begin
      st_next.ser_flag = 1'b1;
    end
    st_next.irq = ~st_reg.cpu_mask & (tirq
      | (st_reg.ser_flag & st_reg.ser_ctrl[`PIS_SC_IE])
      | ((st_reg.f1 | st_reg.f2) & st_reg.ana_ctrl[`PIS_AC_IE]));
    if (rst_i) begin
      st_next = '0;
      // mask set at reset like the processor's own mask
      st_next.cpu_mask = 1'b1;
      st_next.cnt_val = `PIS_CNT_RESET;
      st_next.f1 = 1'b0;
      st_next.f2 = 1'b0;
      // buffer and captured/compare values survive reset
      st_next.ser_buf = st_reg.ser_buf;
      st_next.cap_val = st_reg.cap_val;
      st_next.cmp_val = st_reg.cmp_val;
    end
  end

  always_ff @(posedge clk_i) begin
    st_reg <= st_next;
  end

  assign dat_o = st_reg.rdat;
  assign ack_o = st_reg.ack;
  assign err_o = st_reg.err;
  assign capture_o = st_reg.cap_pulse;
  assign irq_o = st_reg.irq;
endmodule : pis_top

// ===== test/pis_chk.sv
// port checker for the interrupt source block
module pis_chk (
  input wire logic clk_i, // clock
  input wire logic rst_i, // sync reset
  input wire logic cyc_i, // bus cycle
  input wire logic stb_i, // bus strobe
  input wire logic [9:0] adr_i, // byte address
  input wire logic [31:0] dat_o, // read data
  input wire logic ack_o, // acknowledge
  input wire logic err_o, // error
  input wire logic capture_o, // capture pulse
  input wire logic irq_o // processor request
);
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  sequence s_take;
    cyc_i && stb_i && !ack_o && !err_o;
  endsequence
  sequence s_take_idx(logic [7:0] idx);
    s_take ##0 (adr_i[9:2] == idx);
  endsequence
  a_bus_answer: assert property (s_take |=> ack_o || err_o)
    else $error("taken request got no answer");
  a_timer_ack: assert property (s_take_idx(8'h13) |=> ack_o && !err_o)
    else $error("timer status access not acknowledged");
  a_serial_ack: assert property (s_take_idx(8'h0b) |=> ack_o && !err_o)
    else $error("serial status access not acknowledged");
  a_unmapped_err: assert property (s_take_idx(8'h00) |=> err_o && !ack_o)
    else $error("unmapped access not refused");
  a_ack_single: assert property (ack_o |=> !ack_o)
    else $error("ack longer than one cycle");
  a_no_spurious: assert property (!(cyc_i && stb_i) |=> !ack_o && !err_o)
    else $error("answer without request");
  a_read_upper: assert property (ack_o |-> dat_o[31:8] == 24'h0)
    else $error("upper read bits not zero");
  // mask is set by reset, so no request may follow at once
  a_masked_start: assert property ($fell(rst_i) |-> !irq_o [*2])
    else $error("request while global mask set");
  a_reset_quiet: assert property (disable iff (1'b0)
    rst_i |=> !ack_o && !irq_o && !capture_o)
    else $error("outputs active after reset");
endmodule : pis_chk

bind pis_top pis_chk u_chk (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i),
  .adr_i(adr_i), .dat_o(dat_o), .ack_o(ack_o), .err_o(err_o), .capture_o(capture_o),
  .irq_o(irq_o));

// ===== test/pis_cpu_model.sv
// processor side model: accepts each new request the block raises
module pis_cpu_model (
  input wire logic clk_i, // clock
  input wire logic rst_i, // sync reset
  input wire logic irq_i, // request from block
  output int taken_o // requests accepted
);
  timeunit 1ns;
  timeprecision 1ns;
  logic prev_reg;
  always @(posedge clk_i) begin
    if (rst_i) begin
      prev_reg <= 1'b0;
      taken_o <= 0;
    end else begin
      prev_reg <= irq_i;
      if (irq_i === 1'b1 && prev_reg !== 1'b1) taken_o <= taken_o + 1;
    end
  end
endmodule : pis_cpu_model

// ===== test/pis_top_bench.sv
// self-checking bench for the interrupt source block
module pis_top_bench;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_i, rst_i, cyc_i, stb_i, we_i, ext_capture_i, cmp_match_i, cnt_wrap_i;
  logic serial_done_i, cmp1_out_i, cmp2_out_i, ack_o, err_o, capture_o, irq_o;
  logic cap_seen, eb;
  logic [9:0] adr_i;
  logic [3:0] sel_i;
  logic [31:0] dat_i, dat_o, rd;
  logic [7:0] v;
  int err_count, tests_run, taken, seed;
  pis_top dut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
    .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
    .err_o(err_o), .ext_capture_i(ext_capture_i), .cmp_match_i(cmp_match_i),
    .cnt_wrap_i(cnt_wrap_i), .serial_done_i(serial_done_i), .cmp1_out_i(cmp1_out_i),
    .cmp2_out_i(cmp2_out_i), .capture_o(capture_o), .irq_o(irq_o));
  pis_cpu_model cpu (.clk_i(clk_i), .rst_i(rst_i), .irq_i(irq_o), .taken_o(taken));
  initial begin
    clk_i = 1'b0;
    forever #25 clk_i = ~clk_i;
  end
  always @(posedge clk_i) if (capture_o === 1'b1) cap_seen <= 1'b1;
  function automatic logic [31:0] tstat(input logic c, input logic m, input logic o);
    return {24'h0, c, m, o, 5'h0};
  endfunction : tstat
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      err_count++;
      $display("unexpected %s: expected %h seen %h", nm, e, g);
    end
  endtask : chk
  // holds the request until ack or err is sampled, waiting at most 20 cycles before counting a mismatch
  task automatic wb(input logic w, input logic [7:0] idx, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge clk_i);
    {cyc_i, stb_i, we_i} <= {2'b11, w};
    adr_i <= {idx, 2'b00};
    dat_i <= {24'h0, d};
    @(posedge clk_i);
    while (ack_o !== 1'b1 && err_o !== 1'b1 && n < 20) begin
      @(posedge clk_i);
      n++;
    end
    rd = dat_o;
    eb = err_o;
    if (n == 20) err_count++;
    {cyc_i, stb_i} <= 2'b00;
  endtask : wb
  // which: {ext_capture_i, cmp_match_i, cnt_wrap_i, serial_done_i}, one-cycle high
  task automatic pulse(input logic [3:0] which);
    @(posedge clk_i);
    {ext_capture_i, cmp_match_i, cnt_wrap_i, serial_done_i} <= which;
    @(posedge clk_i);
    {ext_capture_i, cmp_match_i, cnt_wrap_i, serial_done_i} <= 4'h0;
    repeat (4) @(posedge clk_i);
  endtask : pulse
  task automatic final_report;
    $display("comparisons %0d mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : final_report
  initial begin
    #2000000;
    err_count++;
    final_report();
  end
  initial begin
    seed = 32'h5c17;
    {cyc_i, stb_i, we_i, ext_capture_i, cmp_match_i, cnt_wrap_i, cap_seen} = '0;
    {serial_done_i, cmp1_out_i, cmp2_out_i, adr_i, dat_i} = '0;
    {sel_i, rst_i, err_count, tests_run} = {4'hf, 1'b1, 64'h0};
    repeat (6) @(posedge clk_i);
    rst_i <= 1'b0;
    wb(1, 8'h12, 8'he2);
    pulse(4'h2);
    chk("irq masked", 0, irq_o);
    wb(1, 8'h1f, 8'h00);
    repeat (2) @(posedge clk_i);
    chk("irq overflow", 1, irq_o);
    wb(0, 8'h13, 0);
    chk("overflow flag", tstat(0, 0, 1), rd & 32'he0);
    wb(0, 8'h11, 0);
    wb(0, 8'h13, 0);
    chk("overflow clear", 0, rd & 32'he0);
    pulse(4'h4);
    chk("irq compare", 1, irq_o);
    wb(0, 8'h13, 0);
    wb(1, 8'h17, 8'h5a);
    wb(0, 8'h13, 0);
    chk("compare clear", 0, rd & 32'he0);
    pulse(4'h8);
    chk("irq capture", 1, irq_o);
    wb(0, 8'h15, 0);
    wb(0, 8'h13, 0);
    chk("capture kept", tstat(1, 0, 0), rd & 32'he0);
    wb(0, 8'h15, 0);
    wb(0, 8'h13, 0);
    chk("capture clear", 0, rd & 32'he0);
    // falling edge select: the pin's trailing edge captures
    wb(1, 8'h12, 8'he0);
    pulse(4'h8);
    wb(0, 8'h13, 0);
    chk("falling capture", tstat(1, 0, 0), rd & 32'he0);
    wb(0, 8'h15, 0);
    wb(1, 8'h12, 8'he2);
    $display("timer test done");
    wb(1, 8'h0a, 8'h80);
    pulse(4'h1);
    chk("irq serial", 1, irq_o);
    wb(0, 8'h0b, 0);
    wb(1, 8'h0c, 8'h3c);
    wb(0, 8'h0b, 0);
    chk("serial data clear", 0, rd & 32'h80);
    pulse(4'h1);
    wb(1, 8'h0a, 8'hc0);
    wb(0, 8'h0b, 0);
    chk("serial bit clear", 0, rd & 32'h80);
    for (int i = 0; i < 4; i++) begin
      v = 8'($random(seed));
      wb(1, 8'h0c, v);
      wb(0, 8'h0c, 0);
      chk("serial buffer", {24'h0, v}, rd);
    end
    $display("serial test done");
    // analog capture enable and analog irq enable set
    wb(1, 8'h1d, 8'hc0);
    cap_seen <= 1'b0;
    for (int i = 0; i < 2; i++) begin
      @(posedge clk_i);
      {cmp1_out_i, cmp2_out_i} <= 2'b10 >> i;
      repeat (6) @(posedge clk_i);
      chk("irq comparator", 1, irq_o);
      wb(0, 8'h1e, 0);
      chk("comparator flag", 32'h80 >> i, rd & 32'hc0);
      {cmp1_out_i, cmp2_out_i} <= 2'b00;
      repeat (4) @(posedge clk_i);
      wb(1, 8'h1e, 8'h20 >> i);
      wb(0, 8'h1e, 0);
      chk("comparator clear", 0, rd & 32'hc0);
    end
    chk("capture pulse", 1, cap_seen);
    wb(0, 8'h13, 0);
    chk("comparator capture", tstat(1, 0, 0), rd & 32'he0);
    wb(0, 8'h15, 0);
    $display("analog test done");
    wb(1, 8'h1f, 8'h01);
    pulse(4'h1);
    chk("irq serial masked", 0, irq_o);
    wb(1, 8'h1f, 8'h00);
    repeat (2) @(posedge clk_i);
    chk("irq unmasked", 1, irq_o);
    wb(1, 8'h0a, 8'hc0);
    chk("requests taken", 1, 32'(taken > 3));
    wb(0, 8'h00, 0);
    chk("unmapped refused", 1, eb);
    pulse(4'h2);
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    wb(0, 8'h12, 0);
    chk("enables kept", 32'he2, rd);
    wb(0, 8'h13, 0);
    chk("flags reset", 0, rd & 32'he0);
    chk("irq after reset", 0, irq_o);
    $display("mask and reset test done");
    final_report();
  end
endmodule : pis_top_bench
